// >>> hw/wdsup_pkg.sv
package wdsup_pkg;

  // **********************************************************************
  // Timing
  // **********************************************************************
  localparam int CLK_PERIOD_NS = 40;
  localparam int WD_MIN_NS = 6800000;
  localparam int WD_MAX_NS = 217360000;
  localparam int HOLD_MIN_NS = 1000000;
  localparam int HOLD_MAX_NS = 116090000;
  localparam int FILT_NS = 1000;
  localparam int KICK_MIN_NS = 6500;
  localparam int FAIL_DLY_NS = 100000;
  localparam int REDL_NS = 1500;

  localparam int WD_W = 23;
  localparam int HOLD_W = 22;
  localparam int CNT_W = 27;
  localparam int FILT_W = 5;
  localparam int DLY_W = 12;

  // Least times round up, longest times round down.
  localparam logic [WD_W-1:0] WD_MIN_CYC = WD_W'((WD_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [WD_W-1:0] WD_MAX_CYC = WD_W'(WD_MAX_NS / CLK_PERIOD_NS);
  localparam logic [HOLD_W-1:0] HOLD_MIN_CYC = HOLD_W'((HOLD_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [HOLD_W-1:0] HOLD_MAX_CYC = HOLD_W'(HOLD_MAX_NS / CLK_PERIOD_NS);
  localparam logic [FILT_W-1:0] FILT_CYC = FILT_W'((FILT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [DLY_W-1:0] FAIL_DLY_CYC = DLY_W'(FAIL_DLY_NS / CLK_PERIOD_NS);
  localparam logic [DLY_W-1:0] REDL_CYC = DLY_W'(REDL_NS / CLK_PERIOD_NS);

  localparam int GATE_FIRST_SHIFT = 3;
  localparam logic [1:0] FAULT_LIMIT = 2'h2;
  localparam logic [1:0] GOOD_LIMIT = 2'h2;

  // **********************************************************************
  // Values after reset
  // **********************************************************************
  localparam logic [1:0] RST_COUNT = 2'h0;
  localparam logic RST_WDI_LEVEL = 1'h1;

  // **********************************************************************
  // Types
  // **********************************************************************
  typedef enum logic [1:0] {VAR_TIMEOUT, VAR_WINDOW, VAR_GATED} wdsVariant_e;

  typedef struct packed {
    wdsVariant_e variant;
    logic openWindowFraction;
    logic [WD_W-1:0] watchdogTimingInput;
    logic [HOLD_W-1:0] resetTimingInput;
  } wdsCfg_s;

  typedef struct packed {
    logic resetN;
    logic resetOe;
    logic failoverN;
    logic failoverOe;
  } wdsPins_s;

endpackage

// >>> hw/wdsup_supervisor.sv
`timescale 1ns/1ps

module wdsup_supervisor #(
  parameter logic [wdsup_pkg::WD_W-1:0] WD_MIN_CYC = wdsup_pkg::WD_MIN_CYC,
  parameter logic [wdsup_pkg::WD_W-1:0] WD_MAX_CYC = wdsup_pkg::WD_MAX_CYC,
  parameter logic [wdsup_pkg::HOLD_W-1:0] HOLD_MIN_CYC = wdsup_pkg::HOLD_MIN_CYC,
  parameter logic [wdsup_pkg::HOLD_W-1:0] HOLD_MAX_CYC = wdsup_pkg::HOLD_MAX_CYC
) (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic clkEn,
  input wire logic watchdogInput,
  input wire logic supplyMonitorInput,
  input wire logic gateInput,
  input wire wdsup_pkg::wdsCfg_s cfg,
  output wdsup_pkg::wdsPins_s pins
);

  typedef enum logic {ST_HOLD, ST_RUN} wdsState_e;

  // **********************************************************************
  // Range limiting
  // **********************************************************************
  function automatic logic [wdsup_pkg::WD_W-1:0] clampPeriod(input logic [wdsup_pkg::WD_W-1:0] v);
    if (v < WD_MIN_CYC) begin
      return WD_MIN_CYC;
    end else if (v > WD_MAX_CYC) begin
      return WD_MAX_CYC;
    end
    return v;
  endfunction

  function automatic logic [wdsup_pkg::HOLD_W-1:0] clampHold(input logic [wdsup_pkg::HOLD_W-1:0] v);
    if (v < HOLD_MIN_CYC) begin
      return HOLD_MIN_CYC;
    end else if (v > HOLD_MAX_CYC) begin
      return HOLD_MAX_CYC;
    end
    return v;
  endfunction

  logic wdiSync1;
  logic wdiSync2;
  logic wdiLevel;
  logic [wdsup_pkg::FILT_W-1:0] filtCnt;
  logic wdiFall;
  wdsState_e state;
  wdsState_e next_state;
  logic [wdsup_pkg::HOLD_W-1:0] holdCnt;
  logic [wdsup_pkg::HOLD_W-1:0] next_holdCnt;
  logic [wdsup_pkg::CNT_W-1:0] wdCnt;
  logic firstPeriod;
  logic gatePrev;
  logic [1:0] faultCnt;
  logic [1:0] goodCnt;
  logic failTarget;
  logic [wdsup_pkg::DLY_W-1:0] dlyCnt;
  logic resetOutN;
  logic resetDrive;
  logic failOutN;
  logic failDrive;

  logic isGated;
  logic isWindow;
  logic wdOff;
  logic gateOk;
  logic supplyLow;
  logic failBlocked;
  logic [wdsup_pkg::WD_W-1:0] periodCyc;
  logic [wdsup_pkg::HOLD_W-1:0] holdCyc;
  logic [wdsup_pkg::CNT_W-1:0] limitCyc;
  logic [wdsup_pkg::CNT_W-1:0] closedCyc;
  logic running;
  logic timeout;
  logic early;
  logic fault;
  logic goodEdge;
  logic [wdsup_pkg::DLY_W-1:0] dlyLimit;

  assign isGated = cfg.variant == wdsup_pkg::VAR_GATED;
  assign isWindow = cfg.variant == wdsup_pkg::VAR_WINDOW;
  assign wdOff = cfg.watchdogTimingInput == '0;
  assign gateOk = !isGated || gateInput;
  assign supplyLow = !isGated && !supplyMonitorInput;
  assign failBlocked = supplyLow || (isGated && !gateInput);
  assign periodCyc = clampPeriod(cfg.watchdogTimingInput);
  assign holdCyc = clampHold(cfg.resetTimingInput);

  assign limitCyc = firstPeriod ? wdsup_pkg::CNT_W'(periodCyc) << wdsup_pkg::GATE_FIRST_SHIFT : wdsup_pkg::CNT_W'(periodCyc);

  // Closed window is the part of the period not given to the open window.
  assign closedCyc = cfg.openWindowFraction ? {6'h00, periodCyc[wdsup_pkg::WD_W-1:2]}
                                            : {5'h00, periodCyc[wdsup_pkg::WD_W-1:1]};

  assign running = state == ST_RUN && !wdOff && gateOk;
  assign timeout = running && wdCnt == limitCyc - wdsup_pkg::CNT_W'(1);
  assign early = running && wdiFall && isWindow && wdCnt < closedCyc;
  assign fault = timeout || early;
  assign goodEdge = running && wdiFall && !early;
  assign dlyLimit = failTarget ? wdsup_pkg::FAIL_DLY_CYC : wdsup_pkg::REDL_CYC;

  // **********************************************************************
  // Kick input conditioning
  // **********************************************************************
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      wdiSync1 <= wdsup_pkg::RST_WDI_LEVEL;
      wdiSync2 <= wdsup_pkg::RST_WDI_LEVEL;
    end else if (clkEn) begin
      wdiSync1 <= watchdogInput;
      wdiSync2 <= wdiSync1;
    end
  end

  // A level change must persist for the filter time before it is taken.
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      wdiLevel <= wdsup_pkg::RST_WDI_LEVEL;
      filtCnt <= '0;
      wdiFall <= 1'h0;
    end else if (clkEn) begin
      wdiFall <= 1'h0;
      if (wdiSync2 == wdiLevel) begin
        filtCnt <= '0;
      end else if (filtCnt == wdsup_pkg::FILT_CYC - wdsup_pkg::FILT_W'(1)) begin
        filtCnt <= '0;
        wdiLevel <= wdiSync2;
        wdiFall <= wdiLevel && !wdiSync2;
      end else begin
        filtCnt <= filtCnt + wdsup_pkg::FILT_W'(1);
      end
    end
  end

  // **********************************************************************
  // Reset output sequencing
  // **********************************************************************
  // Outside the gated variant, a low supply keeps the hold count at zero, so the hold period restarts when it recovers.
  always_comb begin
    next_state = state;
    next_holdCnt = holdCnt;
    if (supplyLow) begin
      next_state = ST_HOLD;
      next_holdCnt = '0;
    end else if (state == ST_HOLD) begin
      if (holdCnt == holdCyc - wdsup_pkg::HOLD_W'(1)) begin
        next_state = ST_RUN;
        next_holdCnt = '0;
      end else begin
        next_holdCnt = holdCnt + wdsup_pkg::HOLD_W'(1);
      end
    end else if (fault && !isGated) begin
      next_state = ST_HOLD;
      next_holdCnt = '0;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      state <= ST_HOLD;
      holdCnt <= '0;
    end else if (clkEn) begin
      state <= next_state;
      holdCnt <= next_holdCnt;
    end
  end

  // The pin is loaded from the next state, so it changes together with the sequencer.
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      resetOutN <= 1'h0;
      resetDrive <= 1'h1;
    end else if (clkEn) begin
      resetOutN <= next_state == ST_RUN;
      resetDrive <= next_state == ST_HOLD;
    end
  end

  // **********************************************************************
  // Watchdog period counter
  // **********************************************************************
  // The count is held at zero whenever the watchdog is not running.
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      wdCnt <= '0;
    end else if (clkEn) begin
      if (!running || wdiFall || fault) begin
        wdCnt <= '0;
      end else begin
        wdCnt <= wdCnt + wdsup_pkg::CNT_W'(1);
      end
    end
  end

  // A rising gate comparator arms a lengthened first period.
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      gatePrev <= 1'h0;
      firstPeriod <= 1'h0;
    end else if (clkEn) begin
      gatePrev <= gateInput;
      if (!isGated) begin
        firstPeriod <= 1'h0;
      end else if (gateInput && !gatePrev) begin
        firstPeriod <= 1'h1;
      end else if (running && (wdiFall || timeout)) begin
        firstPeriod <= 1'h0;
      end
    end
  end

  // **********************************************************************
  // Fault and good-edge tracking
  // **********************************************************************
  // A fault outranks a good edge that lands in the same cycle.
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      faultCnt <= wdsup_pkg::RST_COUNT;
      goodCnt <= wdsup_pkg::RST_COUNT;
      failTarget <= 1'h0;
    end else if (clkEn) begin
      if (fault) begin
        goodCnt <= wdsup_pkg::RST_COUNT;
        if (faultCnt != 2'h3) begin
          faultCnt <= faultCnt + 2'h1;
        end
        if (faultCnt == wdsup_pkg::FAULT_LIMIT || (timeout && firstPeriod)) begin
          failTarget <= 1'h1;
        end
      end else if (goodEdge) begin
        faultCnt <= wdsup_pkg::RST_COUNT;
        if (failTarget) begin
          if (goodCnt == wdsup_pkg::GOOD_LIMIT) begin
            failTarget <= 1'h0;
            goodCnt <= wdsup_pkg::RST_COUNT;
          end else begin
            goodCnt <= goodCnt + 2'h1;
          end
        end
      end
    end
  end

  // **********************************************************************
  // Failover output with its settling delays
  // **********************************************************************
  // Blocking releases the pin at once but keeps the target, so the delay runs again afterwards.
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      dlyCnt <= '0;
      failOutN <= 1'h1;
      failDrive <= 1'h0;
    end else if (clkEn) begin
      if (failBlocked) begin
        dlyCnt <= '0;
        failOutN <= 1'h1;
        failDrive <= 1'h0;
      end else if (failTarget == failDrive) begin
        dlyCnt <= '0;
      end else if (dlyCnt == dlyLimit - wdsup_pkg::DLY_W'(1)) begin
        dlyCnt <= '0;
        failOutN <= !failTarget;
        failDrive <= failTarget;
      end else begin
        dlyCnt <= dlyCnt + wdsup_pkg::DLY_W'(1);
      end
    end
  end

  // **********************************************************************
  // Output pins
  // **********************************************************************
  // The drive enables are the complements of the levels, as the pins are open drain.
  assign pins = '{
    resetN: resetOutN,
    resetOe: resetDrive,
    failoverN: failOutN,
    failoverOe: failDrive
  };

endmodule

// >>> test/wdsup_host.sv
`timescale 1ns/1ps
module wdsup_host (
  input wire logic clk_sys,
  input wire logic [7:0] lowLen,
  input wire logic go,
  output logic watchdogInput
);
  logic [7:0] cnt = 8'h00;
  always_ff @(posedge clk_sys) begin
    if (go) begin
      cnt <= lowLen;
    end else if (cnt != 8'h00) begin
      cnt <= cnt - 8'h01;
    end
  end
  // A kick is a low pulse of lowLen cycles.
  assign watchdogInput = (cnt == 8'h00);
endmodule

// >>> test/wdsup_checker.sv
`timescale 1ns/1ps
module wdsup_checker #(
  parameter logic [wdsup_pkg::WD_W-1:0] WD_MIN_CYC = wdsup_pkg::WD_MIN_CYC,
  parameter logic [wdsup_pkg::WD_W-1:0] WD_MAX_CYC = wdsup_pkg::WD_MAX_CYC,
  parameter logic [wdsup_pkg::HOLD_W-1:0] HOLD_MIN_CYC = wdsup_pkg::HOLD_MIN_CYC,
  parameter logic [wdsup_pkg::HOLD_W-1:0] HOLD_MAX_CYC = wdsup_pkg::HOLD_MAX_CYC
) (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic clkEn,
  input wire logic watchdogInput,
  input wire logic supplyMonitorInput,
  input wire logic gateInput,
  input wire wdsup_pkg::wdsCfg_s cfg,
  input wire wdsup_pkg::wdsPins_s pins
);
  logic [27:0] lowCnt;
  logic [27:0] hiCnt;
  logic ng;
  assign ng = cfg.variant != wdsup_pkg::VAR_GATED;
  always_ff @(posedge clk_sys) begin
    lowCnt <= !rst_n ? 28'hFFFFF : (pins.resetN ? 28'h0 : lowCnt + 28'h1);
  end
  always_ff @(posedge clk_sys) begin
    hiCnt <= (!rst_n || !pins.resetN || $fell(watchdogInput)) ? 28'h0 : hiCnt + 28'h1;
  end
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  property p_por; $rose(rst_n) |-> !pins.resetN && pins.failoverN; endproperty
  a_por: assert property (p_por) else $error("outputs wrong after reset");
  property p_sup; clkEn && ng && !supplyMonitorInput |=> !pins.resetN; endproperty
  a_sup: assert property (p_sup) else $error("low supply without reset");
  property p_fblk; clkEn && ng && !supplyMonitorInput |=> pins.failoverN; endproperty
  a_fblk: assert property (p_fblk) else $error("failover during low supply");
  property p_gblk; clkEn && !ng && !gateInput |=> pins.failoverN; endproperty
  a_gblk: assert property (p_gblk) else $error("failover during low gate");
  property p_hold; $rose(pins.resetN) |-> lowCnt + 28'h1 >= 28'(cfg.resetTimingInput); endproperty
  a_hold: assert property (p_hold) else $error("reset pulse too short");
  property p_dis; pins.resetN && supplyMonitorInput && cfg.watchdogTimingInput == '0 |=> pins.resetN; endproperty
  a_dis: assert property (p_dis) else $error("reset while watchdog off");
  property p_grst; !ng && pins.resetN |=> pins.resetN; endproperty
  a_grst: assert property (p_grst) else $error("reset pulse in gated mode");
  property p_bound;
    ng && pins.resetN && cfg.watchdogTimingInput != '0 |-> hiCnt <= 28'(cfg.watchdogTimingInput) + 28'h20;
  endproperty
  a_bound: assert property (p_bound) else $error("missed timeout");
  property p_roe; pins.resetOe == !pins.resetN; endproperty
  a_roe: assert property (p_roe) else $error("reset drive enable wrong");
  property p_foe; pins.failoverOe == !pins.failoverN; endproperty
  a_foe: assert property (p_foe) else $error("failover drive enable wrong");
  c_fail: cover property ($fell(pins.failoverN));
  c_rel: cover property ($rose(pins.failoverN));
  c_rst: cover property ($fell(pins.resetN));
endmodule

// >>> test/tb_supervisor_watchdog_failover.sv
`timescale 1ns/1ps
module tb_supervisor_watchdog_failover;
  localparam int P = 400;
  localparam int H = 50;
  logic clk_sys = 1'b0;
  logic rst_n = 1'b0;
  logic supply = 1'b1;
  logic gate = 1'b0;
  logic go = 1'b0;
  logic clkEn = 1'b1;
  logic [7:0] lowLen = 8'hAA;
  logic watchdog_input;
  wdsup_pkg::wdsCfg_s cfg = '{wdsup_pkg::VAR_TIMEOUT, 1'b0, 23'h000190, 22'h000032};
  wdsup_pkg::wdsPins_s pins;
  int n_fail = 0;
  int compares = 0;
  int cycles = 0;
  int nRst = 0;
  wdsup_host u_host (.clk_sys(clk_sys), .lowLen(lowLen), .go(go), .watchdogInput(watchdog_input));
  wdsup_supervisor #(.WD_MIN_CYC(23'h000014), .WD_MAX_CYC(23'h000FA0), .HOLD_MIN_CYC(22'h00000A),
    .HOLD_MAX_CYC(22'h0007D0)) u_dut (.clk_sys(clk_sys), .rst_n(rst_n), .clkEn(clkEn), .watchdogInput(watchdog_input),
    .supplyMonitorInput(supply), .gateInput(gate), .cfg(cfg), .pins(pins));
  initial begin
    forever #20 clk_sys = ~clk_sys;
  end
  always @(negedge pins.resetN) nRst++;
  task automatic finish_test;
    $display("compares %0d n_fail %0d", compares, n_fail);
    if (n_fail == 0 && compares > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  always @(posedge clk_sys) begin
    cycles++;
    if (cycles == 30000) begin
      n_fail++;
      finish_test;
    end
  end
  task automatic cyc(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    compares++;
    if (g !== e) begin
      n_fail++;
      $display("CHECK FAILED %s expected %0h seen %0h", nm, e, g);
    end
  endtask
  task automatic kick(input logic [7:0] len);
    lowLen = len;
    go = 1'b1;
    cyc(1);
    go = 1'b0;
  endtask
  task automatic wt(input bit fo, input logic v, input int lim, output int n);
    n = 0;
    while ((fo ? pins.failoverN : pins.resetN) !== v && n < lim) begin
      cyc(1);
      n++;
    end
  endtask
  task automatic t_por;
    int n;
    chk("porRst", 0, pins.resetN);
    chk("porFail", 1, pins.failoverN);
    chk("porRstOe", 1, pins.resetOe);
    chk("porFailOe", 0, pins.failoverOe);
    clkEn = 1'b0;
    cyc(100);
    chk("frozenHold", 0, pins.resetN);
    clkEn = 1'b1;
    wt(0, 1, 200, n);
    chk("porHold", 1, n >= H - 2 && n <= H + 2);
  endtask
  task automatic t_kicks;
    int f;
    f = nRst;
    repeat (6) begin
      kick(8'h0A);
      cyc(90);
    end
    chk("shortKick", 1, nRst != f);
    f = nRst;
    repeat (4) begin
      kick(8'hAA);
      cyc(250);
    end
    chk("goodKicks", 1, nRst == f);
  endtask
  task automatic t_fail;
    int n;
    repeat (3) begin
      wt(0, 1, 100, n);
      wt(0, 0, 600, n);
    end
    chk("failLate", 1, pins.failoverN);
    wt(1, 0, 3000, n);
    chk("failDly", 1, n >= 2497 && n <= 2502);
    chk("failOe", 1, pins.failoverOe);
    wt(0, 1, 600, n);
    kick(8'hAA);
    cyc(250);
    kick(8'hAA);
    cyc(250);
    chk("failHeld", 0, pins.failoverN);
    kick(8'hAA);
    wt(1, 1, 200, n);
    chk("failRel", 1, n >= 55 && n <= 75);
  endtask
  task automatic t_supply;
    int n;
    supply = 1'b0;
    cyc(1);
    chk("supLow", 0, pins.resetN);
    cyc(20);
    supply = 1'b1;
    wt(0, 1, 200, n);
    chk("supHold", 1, n >= H && n <= H + 2);
    cfg.resetTimingInput = '0;
    supply = 1'b0;
    cyc(2);
    supply = 1'b1;
    wt(0, 1, 200, n);
    chk("holdMin", 1, n >= 10 && n <= 12);
    cyc(1);
    cfg.resetTimingInput = 22'h000032;
  endtask
  task automatic t_window;
    int n;
    int f;
    cfg.variant = wdsup_pkg::VAR_WINDOW;
    for (int w = 0; w < 2; w++) begin
      cfg.openWindowFraction = w[0];
      wt(0, 1, 200, n);
      f = nRst;
      cyc(140);
      kick(8'hAA);
      cyc(60);
      chk("winEarly", w == 0, nRst != f);
    end
    f = nRst;
    cfg.watchdogTimingInput = '0;
    cyc(1000);
    chk("wdOff", 1, nRst == f);
  endtask
  task automatic t_gated;
    cfg.watchdogTimingInput = 23'h000190;
    cfg.variant = wdsup_pkg::VAR_GATED;
    gate = 1'b1;
    cyc(5600);
    chk("gateLong", 1, pins.failoverN);
    cyc(200);
    chk("gateFail", 0, pins.failoverN);
    gate = 1'b0;
    cyc(2);
    chk("gateOff", 1, pins.failoverN);
  endtask
  initial begin
    cyc(6);
    rst_n = 1'b1;
    cyc(1);
    t_por;
    t_kicks;
    t_fail;
    t_supply;
    t_window;
    t_gated;
    finish_test;
  end
endmodule
bind wdsup_supervisor wdsup_checker #(.WD_MIN_CYC(WD_MIN_CYC), .WD_MAX_CYC(WD_MAX_CYC),
  .HOLD_MIN_CYC(HOLD_MIN_CYC), .HOLD_MAX_CYC(HOLD_MAX_CYC)) u_chk (.clk_sys(clk_sys), .rst_n(rst_n),
  .clkEn(clkEn), .watchdogInput(watchdogInput), .supplyMonitorInput(supplyMonitorInput),
  .gateInput(gateInput), .cfg(cfg), .pins(pins));
